/* hbc_top.sv */
// Control and protection logic for six half bridge outputs.
// Assumes analog comparators and ripple detectors on pins, and a serial command
// decoder on sys_clk that hands over one-cycle command strobes.
`timescale 1ns/1ns
`default_nettype none
module hbc_top
	import hbc_pkg::*;
#(
	parameter int OC_CYCLES   = OC_DEB_CYC,
	parameter int OV_CYCLES   = OV_DEB_CYC,
	parameter int STOP_CYCLES = STOP_CYC
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic [5:0]  cur_limit,
	input  wire logic        over_temp,
	input  wire logic        thermal_recovery_hysteresis,
	input  wire logic        over_volt,
	input  wire logic [2:0]  ripple_pulse,
	input  wire logic [5:0]  load_sel,
	input  wire logic        cmd_valid,
	input  wire logic [5:0]  cmd_enable,
	input  wire logic [5:0]  cmd_dir,
	input  wire logic        cmd_ack,
	input  wire logic        cmd_go,
	input  wire logic        cmd_brake,
	input  wire logic [2:0]  cmd_motor,
	input  wire logic        cmd_motor_dir,
	output logic [5:0]       hs_on_q,
	output logic [5:0]       ls_on_q,
	output logic             data_ready_n,
	output logic [5:0]       oc_flag_q,
	output logic             ot_flag_q,
	output logic [2:0]       pos_ready_q,
	output logic [2:0]       ripple_count_q,
	output logic [1:0]       detector_input_selector
);
	if (OC_CYCLES < 1 || OV_CYCLES < 1 || STOP_CYCLES < 1) begin : g_bad_counts
		$error("hbc_top: interval counts must be positive");
	end

	// Motor to output pair and detector; 0 means no motor
	function automatic logic [2:0] pair_a(input logic [2:0] m);
		case (m)
			3'h1: pair_a = 3'h0;
			3'h2: pair_a = 3'h2;
			3'h3: pair_a = 3'h4;
			3'h4: pair_a = 3'h1;
			default: pair_a = 3'h3;
		endcase
	endfunction

	function automatic logic [1:0] det_of(input logic [2:0] m);
		det_of = (m == 3'h2) ? 2'h1 : ((m == 3'h3 || m == 3'h5) ? 2'h2 : 2'h0);
	endfunction

	// Three-stage synchronisers; a change counts once stages two and three agree
	logic [SYNC_W-1:0] s1_q, s2_q, s3_q, filt_q, filt_prev_q;
	wire  [SYNC_W-1:0] async_in = {ripple_pulse, cur_limit, over_volt, over_temp, thermal_recovery_hysteresis};

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_q        <= '0;
			s2_q        <= '0;
			s3_q        <= '0;
			filt_q      <= '0;
			filt_prev_q <= '0;
		end else begin
			s1_q        <= async_in;
			s2_q        <= s1_q;
			s3_q        <= s2_q;
			filt_q      <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
			filt_prev_q <= filt_q;
		end
	end

	wire       temp_cool = filt_q[0];
	wire       temp_hot  = filt_q[1];
	wire       volt_high = filt_q[2];
	wire [5:0] cl_level  = filt_q[8:3];
	wire [2:0] rip_edge  = filt_q[11:9] & ~filt_prev_q[11:9];

	// State
	hbc_det_e  det_st_q [NUM_DET];
	logic [2:0] det_mot_q [NUM_DET];
	logic       det_dir_q [NUM_DET];
	logic [5:0] out_en_q, out_dir_q, oc_shut_q;
	logic       ot_lock_q, ov_hold_q, drb_q;
	logic [5:0] oc_done;
	logic [2:0] stop_done;
	logic       ov_on_done, ov_off_done;

	genvar g;
	generate
		for (g = 0; g < NUM_OUT; g++) begin : g_oc
			hbc_timer #(.CYCLES(OC_CYCLES)) u_oc (
				.sys_clk(sys_clk), .rst_b(rst_b), .run(cl_level[g] && !oc_shut_q[g]), .done_q(oc_done[g])
			);
		end
		for (g = 0; g < NUM_DET; g++) begin : g_stop
			// Ripple restarts the interval
			hbc_timer #(.CYCLES(STOP_CYCLES)) u_stop (
				.sys_clk(sys_clk), .rst_b(rst_b), .run(det_st_q[g] == HBC_BRAKE && !rip_edge[g]), .done_q(stop_done[g])
			);
		end
	endgenerate

	hbc_timer #(.CYCLES(OV_CYCLES)) u_ov_on (
		.sys_clk(sys_clk), .rst_b(rst_b), .run(volt_high && !ov_hold_q), .done_q(ov_on_done)
	);
	hbc_timer #(.CYCLES(OV_CYCLES)) u_ov_off (
		.sys_clk(sys_clk), .rst_b(rst_b), .run(!volt_high && ov_hold_q), .done_q(ov_off_done)
	);

	// Command qualification
	wire       diag_open = (|oc_flag_q) || ot_flag_q;
	wire       ack_now   = cmd_valid && cmd_ack;
	wire       en_block  = diag_open && !ack_now;
	wire [5:0] en_req    = cmd_valid ? cmd_enable : 6'h00;
	wire [5:0] en_take   = (ot_lock_q || en_block) ? 6'h00 : en_req;
	wire       en_refuse = (|en_req) && (ot_lock_q || en_block);
	wire [1:0] go_det    = det_of(cmd_motor);
	wire [2:0] go_a      = pair_a(cmd_motor);
	wire       go_ok     = cmd_go && cmd_motor != MOTOR_NONE && cmd_motor <= 3'h5 && !ot_lock_q
		&& !load_sel[go_a] && !load_sel[go_a + 3'h1];
	wire       ot_event  = temp_hot && !ot_lock_q;
	wire       ack_clear = ack_now && !temp_hot;

	// Detector state machines and position flags
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int d = 0; d < NUM_DET; d++) begin
				det_st_q[d]  <= HBC_IDLE;
				det_mot_q[d] <= MOTOR_NONE;
				det_dir_q[d] <= 1'b0;
			end
			pos_ready_q    <= 3'h0;
			ripple_count_q <= 3'h0;
		end else begin
			for (int d = 0; d < NUM_DET; d++) begin
				ripple_count_q[d] <= rip_edge[d] && det_st_q[d] != HBC_IDLE;
				if (ack_now) pos_ready_q[d] <= 1'b0;
				case (det_st_q[d])
					HBC_IDLE: begin
						if (go_ok && go_det == 2'(d)) begin
							det_st_q[d]  <= HBC_RUN;
							det_mot_q[d] <= cmd_motor;
							det_dir_q[d] <= cmd_motor_dir;
						end
					end
					HBC_RUN: begin
						if (cmd_brake && det_mot_q[d] == cmd_motor) det_st_q[d] <= HBC_BRAKE;
					end
					default: begin
						if (stop_done[d]) begin
							det_st_q[d]    <= HBC_IDLE;
							pos_ready_q[d] <= 1'b1;
						end
					end
				endcase
				// Overtemperature or a trip on the motor's pair aborts positioning, overvoltage does not; outputs are tristated below
				// An idle detector keeps its last motor; a stale pair must not block a new start
				if (det_st_q[d] != HBC_IDLE
					&& (ot_lock_q || oc_shut_q[pair_a(det_mot_q[d])] || oc_shut_q[pair_a(det_mot_q[d]) + 3'h1])) begin
					det_st_q[d] <= HBC_IDLE;
				end
			end
		end
	end

	// Protection and diagnostics; sets win over clears, except that a trip or overtemperature wins over an output enable
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			out_en_q  <= 6'h00;
			out_dir_q <= 6'h00;
			oc_shut_q <= 6'h00;
			oc_flag_q <= 6'h00;
			ot_flag_q <= 1'b0;
			ot_lock_q <= 1'b0;
			ov_hold_q <= 1'b0;
			drb_q     <= 1'b0;
		end else begin
			out_en_q  <= (out_en_q | en_take) & ~oc_done & ~{6{temp_hot}};
			out_dir_q <= cmd_valid ? cmd_dir : out_dir_q;
			oc_shut_q <= (oc_shut_q & ~en_take) | oc_done;
			oc_flag_q <= (ack_now ? 6'h00 : oc_flag_q) | oc_done;
			ot_flag_q <= (ack_clear ? 1'b0 : ot_flag_q) | ot_event;
			ot_lock_q <= temp_hot || (ot_lock_q && !temp_cool);
			ov_hold_q <= ov_on_done || (ov_hold_q && !ov_off_done);
			// Supply faults never reach the flag or the diagnostics
			drb_q     <= (drb_q && !ack_clear) || (|oc_done) || ot_event || en_refuse || (|stop_done);
		end
	end

	// Output drive: all bridges default to tristate
	logic [5:0] hs_d, ls_d;
	always_comb begin
		logic [2:0] a;
		a    = 3'h0;
		hs_d = 6'h00;
		ls_d = 6'h00;
		for (int d = 0; d < NUM_DET; d++) begin
			a = pair_a(det_mot_q[d]);
			if (det_st_q[d] == HBC_RUN) begin
				hs_d[a]        = det_dir_q[d];
				ls_d[a]        = !det_dir_q[d];
				hs_d[a + 3'h1] = !det_dir_q[d];
				ls_d[a + 3'h1] = det_dir_q[d];
			end else if (det_st_q[d] == HBC_BRAKE) begin
				ls_d[a]        = 1'b1;
				ls_d[a + 3'h1] = 1'b1;
			end
		end
		for (int i = 0; i < NUM_OUT; i++) begin
			// Undervoltage is deliberately not an input here
			if (load_sel[i]) begin
				hs_d[i] = out_en_q[i] && out_dir_q[i] && !ov_hold_q;
				ls_d[i] = (out_en_q[i] && !out_dir_q[i]) || (ov_hold_q && !oc_shut_q[i] && !ot_lock_q);
			end
			if (ot_lock_q || oc_shut_q[i]) begin
				hs_d[i] = 1'b0;
				ls_d[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			hs_on_q                 <= 6'h00;
			ls_on_q                 <= 6'h00;
			data_ready_n            <= 1'b1;
			detector_input_selector <= 2'h0;
		end else begin
			hs_on_q      <= hs_d;
			ls_on_q      <= ls_d;
			data_ready_n <= !drb_q;
			// Detector one picks 2/3 for motor four, detector three picks 4/5 for motor five
			detector_input_selector <= {det_mot_q[2] == 3'h5, det_mot_q[0] == 3'h4};
		end
	end
endmodule
`default_nettype wire

/* hbc_timer.sv */
// Shared constants of the half bridge output control block, and the restartable
// interval timer used for every debounce and motor-stop interval.
// Assumes one 50 MHz clock and an active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
package hbc_pkg;
	localparam int CLK_KHZ       = 50000;
	localparam int OC_DEB_US     = 500;
	localparam int OV_DEB_MS     = 10;
	localparam int STOP_MS       = 100;
	localparam int OC_DEB_CYC    = (OC_DEB_US * CLK_KHZ + 999) / 1000;
	localparam int OV_DEB_CYC    = OV_DEB_MS * CLK_KHZ;
	localparam int STOP_CYC      = STOP_MS * CLK_KHZ;
	localparam int NUM_OUT       = 6;
	localparam int NUM_DET       = 3;
	localparam int SYNC_W        = 12;
	localparam logic [2:0] MOTOR_NONE = 3'h0;
	typedef enum logic [1:0] {HBC_IDLE, HBC_RUN, HBC_BRAKE} hbc_det_e;
endpackage

module hbc_timer #(
	parameter int CYCLES = 16
) (
	input  wire logic sys_clk,
	input  wire logic rst_b,
	input  wire logic run,
	output logic      done_q
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
	localparam logic [CW-1:0] FULL = CW'(CYCLES);

	logic [CW-1:0] cnt_q;

	// Refused at elaboration; a zero-length interval has no last count
	if (CYCLES < 1) begin : g_bad_cycles
		$error("hbc_timer: CYCLES must be at least 1");
	end

	// Count restarts as soon as the qualifying condition lapses
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q  <= '0;
			done_q <= 1'b0;
		end else begin
			cnt_q  <= !run ? '0 : (cnt_q == FULL ? cnt_q : cnt_q + 1'b1);
			done_q <= run && (cnt_q == LAST);
		end
	end
endmodule
`default_nettype wire

/* hbc_motor_model.sv */
// Behavioural motors and loads on the six half bridges.
// Assumes the bench raises short_req to fake a shorted output.
`timescale 1ns/1ns
`default_nettype none
module hbc_motor_model (
	input  wire logic [5:0] hs_on_q,
	input  wire logic [5:0] ls_on_q,
	input  wire logic [5:0] short_req,
	input  wire logic       sys_clk,
	output logic      [5:0] cur_limit,
	output logic      [2:0] ripple_pulse
);
	logic [1:0] ph_q = 2'h0;
	// Limit current only flows while a shorted bridge is really driven
	assign cur_limit = short_req & (hs_on_q | ls_on_q);
	always @(posedge sys_clk)
		ph_q <= ph_q + 2'h1;
	// No ripple in brake, so a braked rotor runs out silently
	// Two cycles high, or the pin filter would swallow every pulse
	assign ripple_pulse = (ph_q[1] == 1'b0) ? {|hs_on_q[5:3], |hs_on_q[3:2], |hs_on_q[2:0]} : 3'h0;
endmodule
`default_nettype wire

/* hbc_top_asserts.sv */
// Port checks for the half bridge output control top.
// Assumes load_sel stays steady while loads are driven.
`timescale 1ns/1ns
`default_nettype none
module hbc_top_asserts #(
	parameter int OC_CYCLES = 8,
	parameter int OV_CYCLES = 16
) (
	input wire logic       sys_clk,
	input wire logic       rst_b,
	input wire logic [5:0] cur_limit,
	input wire logic       over_volt,
	input wire logic [5:0] load_sel,
	input wire logic       cmd_valid,
	input wire logic [5:0] cmd_dir,
	input wire logic [5:0] hs_on_q,
	input wire logic [5:0] ls_on_q,
	input wire logic       data_ready_n,
	input wire logic [5:0] oc_flag_q,
	input wire logic       ot_flag_q,
	input wire logic [2:0] pos_ready_q,
	input wire logic [2:0] ripple_count_q
);
	int         oc_q [6];
	int         ov_q;
	logic [5:0] dir_q;
	logic [5:0] long_w;
	// Raw pin run lengths; one low cycle restarts them
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ov_q <= 0;
			dir_q <= 6'h00;
			oc_q <= '{default: 0};
		end else begin
			ov_q <= over_volt ? ov_q + 1 : 0;
			dir_q <= cmd_valid ? cmd_dir : dir_q;
			for (int i = 0; i < 6; i++)
				oc_q[i] <= cur_limit[i] ? oc_q[i] + 1 : 0;
		end
	end
	always_comb
		for (int i = 0; i < 6; i++)
			long_w[i] = oc_q[i] >= OC_CYCLES;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	a_oc_debounce: assert property ((oc_flag_q & ~$past(oc_flag_q) & ~long_w) == 6'h00)
		else $error("trip before debounce");
	a_oc_held_off: assert property ((oc_flag_q & $past(oc_flag_q, 2) & (hs_on_q | ls_on_q)) == 6'h00)
		else $error("tripped output driven");
	a_oc_ready: assert property ($rose(|oc_flag_q) |-> ##[0:3] !data_ready_n)
		else $error("no ready after trip");
	a_ot_all_off: assert property (ot_flag_q && $past(ot_flag_q, 2) |-> (hs_on_q | ls_on_q) == 6'h00)
		else $error("output on in overtemp");
	a_ready_cause: assert property ($fell(data_ready_n) |-> ##[0:1] (|oc_flag_q || |pos_ready_q || ot_flag_q
		|| $past(cmd_valid) || $past(cmd_valid, 2) || $past(cmd_valid, 3)))
		else $error("ready without cause");
	a_load_dir: assert property ((hs_on_q & load_sel & ~(dir_q | $past(dir_q) | $past(dir_q, 2))) == 6'h00)
		else $error("load high with dir 0");
	a_ov_low: assert property (ov_q > OV_CYCLES + 6 |-> (hs_on_q & load_sel) == 6'h00)
		else $error("load high in overvoltage");
	a_load_no_ripple: assert property (load_sel[5:4] == 2'b11 |-> !ripple_count_q[2])
		else $error("ripple on load pair");
	c_oc: cover property ($rose(|oc_flag_q));
	c_ot: cover property ($rose(ot_flag_q));
	c_stop: cover property ($rose(|pos_ready_q));
endmodule
bind hbc_top hbc_top_asserts #(.OC_CYCLES(OC_CYCLES), .OV_CYCLES(OV_CYCLES)) chk_u (.*);
`default_nettype wire

/* half_bridge_output_control_test.sv */
// Self-checking bench for the half bridge output control top.
// Assumes the motor model on the bridges and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module half_bridge_output_control_test;
	localparam int OC = 8, OV = 16, ST = 20;
	logic       sys_clk, rst_b, over_temp, thermal_recovery_hysteresis, over_volt, cmd_valid, cmd_ack;
	logic       cmd_go, cmd_brake, cmd_motor_dir, data_ready_n, ot_flag_q;
	logic [5:0] cur_limit, load_sel, cmd_enable, cmd_dir, short_req, hs_on_q, ls_on_q, oc_flag_q, d, rc;
	logic [2:0] ripple_pulse, cmd_motor, pos_ready_q, ripple_count_q;
	logic [1:0] detector_input_selector;
	int         err_total, n_checks;
	hbc_top #(.OC_CYCLES(OC), .OV_CYCLES(OV), .STOP_CYCLES(ST)) dut_u (.*);
	hbc_motor_model mdl_u (.*);
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	function automatic int lo(input int m);
		return m < 4 ? 2 * m - 2 : 2 * m - 7;
	endfunction
	function automatic int dt(input int m);
		return m == 2 ? 1 : (m == 3 || m == 5) ? 2 : 0;
	endfunction
	function automatic logic [1:0] sm(input int m);
		return m == 2 ? 2'h0 : (m == 1 || m == 4) ? 2'h1 : 2'h2;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// v picks output control, go or brake
	task automatic send(input logic [2:0] v, input logic [5:0] en, input logic [5:0] dr, input logic ak, input int m);
		{cmd_brake, cmd_go, cmd_valid} = v;
		cmd_enable = en;
		cmd_dir = dr;
		cmd_motor_dir = dr[0];
		cmd_ack = ak;
		cmd_motor = 3'(m);
		cyc(1);
		{cmd_brake, cmd_go, cmd_valid} = 3'h0;
	endtask
	task automatic chk(input string nm, input logic [5:0] e, input logic [5:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#100000;
		err_total++;
		$display("FAIL watchdog expected done seen timeout");
		summarize();
	end
	initial begin
		void'($urandom(32'hbfa3));
		{rst_b, over_temp, over_volt, cmd_valid, cmd_go, cmd_brake, cmd_ack, cmd_motor_dir} = 8'h00;
		{cmd_enable, cmd_dir, short_req, cmd_motor} = 21'h00_0000;
		thermal_recovery_hysteresis = 1'b1;
		load_sel = 6'h30;
		cyc(10);
		rst_b = 1'b1;
		cyc(2);
		for (int i = 0; i < 5; i++) begin
			d = i < 2 ? {6{i[0]}} : 6'($urandom);
			send(3'h1, 6'h30, d, 1'b0, 0);
			cyc(3);
			chk("load_hs", d & 6'h30, hs_on_q & 6'h30);
			chk("load_ls", ~d & 6'h30, ls_on_q & 6'h30);
		end
		$display("test load_dir done");
		send(3'h1, 6'h30, 6'h10, 1'b0, 0);
		// A dip the pin filter sees must restart the debounce; one cycle is filtered out
		over_volt = 1'b1;
		cyc(OV - 4);
		over_volt = 1'b0;
		cyc(3);
		over_volt = 1'b1;
		cyc(OV - 4);
		chk("ov_restart", 6'h10, hs_on_q);
		cyc(12);
		chk("ov_low", 6'h30, ls_on_q);
		chk("ov_drb", 6'h01, {5'h00, data_ready_n});
		over_volt = 1'b0;
		cyc(OV + 8);
		chk("ov_back", 6'h10, hs_on_q);
		chk("ov_drb2", 6'h01, {5'h00, data_ready_n});
		$display("test overvoltage done");
		repeat (3) begin
			short_req = 6'h10;
			cyc(OC - 3);
			short_req = 6'h00;
			cyc(3);
		end
		chk("oc_restart", 6'h00, oc_flag_q);
		short_req = 6'h10;
		cyc(OC + 8);
		short_req = 6'h00;
		chk("oc_flag", 6'h10, oc_flag_q);
		chk("oc_off", 6'h00, (hs_on_q | ls_on_q) & 6'h10);
		chk("oc_drb", 6'h00, {5'h00, data_ready_n});
		send(3'h1, 6'h10, 6'h10, 1'b0, 0);
		cyc(3);
		chk("oc_refused", 6'h00, hs_on_q & 6'h10);
		chk("oc_drb2", 6'h00, {5'h00, data_ready_n});
		send(3'h1, 6'h10, 6'h10, 1'b1, 0);
		cyc(3);
		chk("oc_back", 6'h10, hs_on_q);
		chk("oc_ack", 6'h00, oc_flag_q);
		chk("oc_drb3", 6'h01, {5'h00, data_ready_n});
		$display("test overcurrent done");
		over_temp = 1'b1;
		thermal_recovery_hysteresis = 1'b0;
		cyc(8);
		chk("ot_off", 6'h00, hs_on_q | ls_on_q);
		chk("ot_flag", 6'h01, {5'h00, ot_flag_q});
		chk("ot_drb", 6'h00, {5'h00, data_ready_n});
		over_temp = 1'b0;
		cyc(6);
		send(3'h1, 6'h30, 6'h30, 1'b1, 0);
		cyc(3);
		chk("ot_locked", 6'h00, hs_on_q);
		thermal_recovery_hysteresis = 1'b1;
		cyc(6);
		send(3'h1, 6'h30, 6'h30, 1'b1, 0);
		cyc(3);
		chk("ot_back", 6'h30, hs_on_q);
		$display("test overtemp done");
		// Second reset frees outputs five and six for motor use
		rst_b = 1'b0;
		load_sel = 6'h00;
		cyc(2);
		rst_b = 1'b1;
		cyc(2);
		for (int m = 1; m <= 5; m++) begin
			d = 6'($urandom);
			send(3'h2, 6'h00, d, 1'b0, m);
			cyc(3);
			chk("run_hs", (d[0] ? 6'h01 : 6'h02) << lo(m), hs_on_q);
			chk("run_ls", (d[0] ? 6'h02 : 6'h01) << lo(m), ls_on_q);
			chk("sel", m > 3 ? {4'h0, sm(m)} : 6'h00, {4'h0, detector_input_selector & sm(m)});
			rc = 6'h00;
			repeat (8) begin
				cyc(1);
				rc[2:0] = rc[2:0] | ripple_count_q;
			end
			chk("ripple", {3'h0, 3'h1 << dt(m)}, rc);
			send(3'h4, 6'h00, d, 1'b0, m);
			cyc(3);
			chk("brk_ls", 6'h03 << lo(m), ls_on_q);
			chk("brk_hs", 6'h00, hs_on_q);
			cyc(ST + 10);
			chk("stop", 6'h00, hs_on_q | ls_on_q);
			chk("pos", {3'h0, 3'h1 << dt(m)}, {3'h0, pos_ready_q});
			send(3'h1, 6'h00, 6'h00, 1'b1, 0);
			cyc(2);
		end
		$display("test motors done");
		summarize();
	end
endmodule
`default_nettype wire
